// File: synth_cal_pkg.sv
// Register map, field positions, reset values and states of the synthesizer control block
package synth_cal_pkg;

  // Register offsets
  localparam logic [11:0] ADDR_UPDATE    = 12'h00f;
  localparam logic [11:0] ADDR_STATUS    = 12'h020;
  localparam logic [11:0] ADDR_CAL_CTRL  = 12'h100;
  localparam logic [11:0] ADDR_LOOP_MODE = 12'h101;
  localparam logic [11:0] ADDR_PUMP      = 12'h102;
  localparam logic [11:0] ADDR_FILTER    = 12'h103;
  localparam logic [11:0] ADDR_FSEL      = 12'h104;
  localparam logic [11:0] ADDR_PD_RESET  = 12'h120;
  localparam logic [11:0] ADDR_PD_RATIO  = 12'h121;
  localparam logic [11:0] ADDR_CH_SRC    = 12'h122;

  // Field positions
  localparam int CAL_START_BIT   = 3;
  localparam int STATUS_BUSY_BIT = 2;
  localparam int LOOP_MODE_LSB   = 1;
  localparam int LOOP_MODE_MSB   = 2;
  localparam int FSEL_BIT        = 0;
  localparam int PD_RST_PRI_BIT  = 0;
  localparam int PD_RST_SEC_BIT  = 4;
  localparam int RES_MSB         = 7;
  localparam int RES_LSB         = 6;
  localparam int RATIO_PRI_LSB   = 0;
  localparam int RATIO_SEC_LSB   = 4;

  // Values after reset
  localparam logic [7:0] PUMP_RST   = 8'h8d;
  localparam logic [7:0] REG_RST    = 8'h00;
  localparam logic [1:0] LOOP_RST   = 2'h0;
  localparam logic [3:0] CH_SRC_RST = 4'h0;
  localparam logic [7:0] BAND_RST   = 8'h80;

  // Codes and limits
  localparam logic [7:0]  UPDATE_APPLY    = 8'h01;
  localparam logic [9:0]  PUMP_STEP_UA    = 10'h004;
  localparam logic [1:0]  LOOP_MODE0      = 2'h0;
  localparam logic [1:0]  LOOP_MODE1      = 2'h1;
  localparam logic [1:0]  LOOP_MODE2      = 2'h2;
  localparam logic [15:0] FB_DIV_GATE_MIN = 16'h0200;
  localparam logic [3:0]  DIV_MIN         = 4'h2;
  localparam logic [3:0]  DIV_MAX         = 4'hb;
  localparam logic [3:0]  SEC_ALLOWED     = 4'h6;

  // Calibration length in phase detector cycles, split over one step per band bit
  localparam int unsigned CAL_PFD_CYCLES = 98500;
  localparam int unsigned CAL_STEPS      = 8;

  typedef enum logic [1:0] {CAL_IDLE, CAL_WAIT_REF, CAL_RUN} cal_state_t;

endpackage : synth_cal_pkg

// File: post_div_if.sv
// Carrier between the control logic and the two oscillator post-dividers
`timescale 1ns/1ps
interface post_div_if;
  logic [3:0] ratio    [2];
  logic       rst_req  [2];
  logic [3:0] divide   [2];
  logic       powered  [2];
  logic       in_reset [2];
  modport ctrl (output ratio, rst_req, input divide, powered, in_reset);
  modport div  (input ratio, rst_req, output divide, powered, in_reset);
endinterface : post_div_if

// File: post_divider_ctrl.sv
// Ratio decode and synchronous reset of the primary and secondary post-dividers
`timescale 1ns/1ps
module post_divider_ctrl (
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic rstn,
  // Divider side
  post_div_if.div   pd
);

  function automatic logic ratio_valid(input logic [3:0] code);
    ratio_valid = (code >= synth_cal_pkg::DIV_MIN) && (code <= synth_cal_pkg::DIV_MAX);
  endfunction : ratio_valid

  for (genvar i = 0; i < 2; i++) begin : g_div
    always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
        pd.divide[i]   <= 4'h0;
        pd.powered[i]  <= 1'b0;
        pd.in_reset[i] <= 1'b1;
      end else begin
        pd.powered[i]  <= ratio_valid(pd.ratio[i]);
        pd.divide[i]   <= ratio_valid(pd.ratio[i]) ? pd.ratio[i] : 4'h0;
        pd.in_reset[i] <= pd.rst_req[i];
      end
    end
  end

endmodule : post_divider_ctrl

// File: synth_divider_calibration_ctrl.sv
// Control of the fractional loop: pump, filter, post-dividers and oscillator band calibration
//
// Added by the designer: strobed register access.
`timescale 1ns/1ps
// Behaviour
// - Pump current equals field times four microamps
// - Filter select bit chooses internal or external
// - External mode uses only resistor bits
// - Calibration picks one of 256 bands
// - Primary ratio low nibble, secondary high
// - Codes 2..11 divide, others power down
// - Secondary may feed channels one, two only
// - Calibration resets both post-dividers synchronously
// - Calibration waits for valid reference flag
// - Mode one, division 512+: skip flag
// - Preset load completion starts calibration
// - Calibration bit starts run, not self-clearing
// - Status bit high while calibration runs
// - First calibration holds distribution in sync
// - Run lasts about 98500 detector cycles
// - Loop mode field selects mode zero, one or two
module synth_divider_calibration_ctrl #(
  parameter int unsigned CAL_PFD_CYCLES = synth_cal_pkg::CAL_PFD_CYCLES
) (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rstn,
  // Register port
  input  wire logic [11:0] reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  // Pins from the analog side and the reference monitor
  input  wire logic        pfd_clk_pin,
  input  wire logic        reference_loss_flag,
  input  wire logic        osc_above_target,
  input  wire logic        pin_strap_preset_done,
  input  wire logic        fractional_loop_reset,
  // Total feedback division from the feedback divider block
  input  wire logic [15:0] feedback_div_total,
  // Loop controls
  output logic      [7:0]  pump_current_code,
  output logic      [9:0]  pump_current_ua,
  output logic             filter_external,
  output logic      [7:0]  filter_components,
  output logic      [1:0]  second_pole_resistor,
  output logic      [1:0]  loop_mode,
  output logic      [7:0]  main_oscillator_band,
  // Post-dividers and distribution
  output logic      [3:0]  primary_post_divider,
  output logic             primary_post_divider_on,
  output logic             primary_post_divider_rst,
  output logic      [3:0]  secondary_post_divider,
  output logic             secondary_post_divider_on,
  output logic             secondary_post_divider_rst,
  output logic      [3:0]  channel_from_secondary,
  output logic             distribution_hold,
  output logic             cal_busy
);

  localparam int unsigned STEP_LEN = CAL_PFD_CYCLES / synth_cal_pkg::CAL_STEPS;
  localparam int STEP_W = $clog2(STEP_LEN + 1);
  localparam logic [STEP_W-1:0] STEP_LAST = STEP_W'(STEP_LEN - 1);

  // Pin synchronisers: pfd clock, reference loss, above target, preset done, loop reset
  logic [4:0] sync1_ff;
  logic [4:0] sync2_ff;
  logic [4:0] sync3_ff;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      sync1_ff <= 5'h00;
      sync2_ff <= 5'h00;
      sync3_ff <= 5'h00;
    end else begin
      sync1_ff <= {fractional_loop_reset, pin_strap_preset_done, osc_above_target,
                   reference_loss_flag, pfd_clk_pin};
      sync2_ff <= sync1_ff;
      sync3_ff <= sync2_ff;
    end
  end

  logic pfd_tick;
  logic ref_lost;
  logic above;
  logic preset_rise;
  logic loop_rst_rise;
  assign pfd_tick      = sync2_ff[0] & ~sync3_ff[0];
  assign ref_lost      = sync2_ff[1];
  assign above         = sync2_ff[2];
  assign preset_rise   = sync2_ff[3] & ~sync3_ff[3];
  assign loop_rst_rise = sync2_ff[4] & ~sync3_ff[4];

  // Shadow registers written by software
  logic [7:0] sh_cal_ff;
  logic [1:0] sh_loop_ff;
  logic [7:0] sh_pump_ff;
  logic [7:0] sh_filter_ff;
  logic       sh_fsel_ff;
  logic [7:0] sh_pd_rst_ff;
  logic [7:0] sh_ratio_ff;
  logic [3:0] sh_ch_src_ff;

  function automatic logic hit(input logic [11:0] a, input logic [11:0] target);
    hit = (a == target);
  endfunction : hit

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      sh_cal_ff    <= synth_cal_pkg::REG_RST;
      sh_loop_ff   <= synth_cal_pkg::LOOP_RST;
      sh_pump_ff   <= synth_cal_pkg::PUMP_RST;
      sh_filter_ff <= synth_cal_pkg::REG_RST;
      sh_fsel_ff   <= 1'b0;
      sh_pd_rst_ff <= synth_cal_pkg::REG_RST;
      sh_ratio_ff  <= synth_cal_pkg::REG_RST;
      sh_ch_src_ff <= synth_cal_pkg::CH_SRC_RST;
    end else if (reg_wr) begin
      if (hit(reg_addr, synth_cal_pkg::ADDR_CAL_CTRL)) sh_cal_ff <= reg_wdata;
      if (hit(reg_addr, synth_cal_pkg::ADDR_LOOP_MODE)) begin
        sh_loop_ff <= reg_wdata[synth_cal_pkg::LOOP_MODE_MSB:synth_cal_pkg::LOOP_MODE_LSB];
      end
      if (hit(reg_addr, synth_cal_pkg::ADDR_PUMP)) sh_pump_ff <= reg_wdata;
      if (hit(reg_addr, synth_cal_pkg::ADDR_FILTER)) sh_filter_ff <= reg_wdata;
      if (hit(reg_addr, synth_cal_pkg::ADDR_FSEL)) sh_fsel_ff <= reg_wdata[synth_cal_pkg::FSEL_BIT];
      if (hit(reg_addr, synth_cal_pkg::ADDR_PD_RESET)) sh_pd_rst_ff <= reg_wdata;
      if (hit(reg_addr, synth_cal_pkg::ADDR_PD_RATIO)) sh_ratio_ff <= reg_wdata;
      if (hit(reg_addr, synth_cal_pkg::ADDR_CH_SRC)) begin
        sh_ch_src_ff <= reg_wdata[3:0] & synth_cal_pkg::SEC_ALLOWED;
      end
    end
  end

  // Active copies, loaded together by the update strobe
  logic apply;
  assign apply = reg_wr && hit(reg_addr, synth_cal_pkg::ADDR_UPDATE)
                 && (reg_wdata == synth_cal_pkg::UPDATE_APPLY);

  logic       act_cal_ff;
  logic [1:0] act_loop_ff;
  logic [7:0] act_pump_ff;
  logic [7:0] act_filter_ff;
  logic       act_fsel_ff;
  logic [1:0] act_pd_rst_ff;
  logic [7:0] act_ratio_ff;
  logic [3:0] act_ch_src_ff;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      act_cal_ff    <= 1'b0;
      act_loop_ff   <= synth_cal_pkg::LOOP_RST;
      act_pump_ff   <= synth_cal_pkg::PUMP_RST;
      act_filter_ff <= synth_cal_pkg::REG_RST;
      act_fsel_ff   <= 1'b0;
      act_pd_rst_ff <= 2'h0;
      act_ratio_ff  <= synth_cal_pkg::REG_RST;
      act_ch_src_ff <= synth_cal_pkg::CH_SRC_RST;
    end else if (apply) begin
      act_cal_ff    <= sh_cal_ff[synth_cal_pkg::CAL_START_BIT];
      act_loop_ff   <= sh_loop_ff;
      act_pump_ff   <= sh_pump_ff;
      act_filter_ff <= sh_filter_ff;
      act_fsel_ff   <= sh_fsel_ff;
      act_pd_rst_ff <= {sh_pd_rst_ff[synth_cal_pkg::PD_RST_SEC_BIT], sh_pd_rst_ff[synth_cal_pkg::PD_RST_PRI_BIT]};
      act_ratio_ff  <= sh_ratio_ff;
      act_ch_src_ff <= sh_ch_src_ff;
    end
  end

  // Calibration start: applied rising edge of the bit, or end of preset load
  logic man_start;
  logic cal_start;
  assign man_start = apply && sh_cal_ff[synth_cal_pkg::CAL_START_BIT] && !act_cal_ff;
  assign cal_start = man_start || preset_rise;

  // Reference gating is dropped in loop mode 1 with a deep feedback division
  logic gate_bypass;
  assign gate_bypass = (act_loop_ff == synth_cal_pkg::LOOP_MODE1)
                       && (feedback_div_total >= synth_cal_pkg::FB_DIV_GATE_MIN);

  // Calibration sequencer
  synth_cal_pkg::cal_state_t state_ff;
  synth_cal_pkg::cal_state_t nxt_state;
  logic [STEP_W-1:0] step_cnt_ff;
  logic [2:0]        bit_idx_ff;
  logic              step_done;
  assign step_done = pfd_tick && (step_cnt_ff == STEP_LAST);

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      synth_cal_pkg::CAL_IDLE: begin
        if (cal_start) nxt_state = synth_cal_pkg::CAL_WAIT_REF;
      end
      synth_cal_pkg::CAL_WAIT_REF: begin
        if (gate_bypass ? pfd_tick : !ref_lost) nxt_state = synth_cal_pkg::CAL_RUN;
      end
      synth_cal_pkg::CAL_RUN: begin
        if (step_done && bit_idx_ff == 3'h0) nxt_state = synth_cal_pkg::CAL_IDLE;
      end
      default: nxt_state = synth_cal_pkg::CAL_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) state_ff <= synth_cal_pkg::CAL_IDLE;
    else state_ff <= nxt_state;
  end

  // Step timing in phase detector cycles
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      step_cnt_ff <= '0;
    end else if (state_ff != synth_cal_pkg::CAL_RUN) begin
      step_cnt_ff <= '0;
    end else if (pfd_tick) begin
      step_cnt_ff <= step_done ? '0 : step_cnt_ff + STEP_W'(1);
    end
  end

  // Band search, most significant bit first
  logic [7:0] band_ff;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      band_ff    <= synth_cal_pkg::BAND_RST;
      bit_idx_ff <= 3'h7;
    end else if (state_ff == synth_cal_pkg::CAL_IDLE && cal_start) begin
      band_ff    <= synth_cal_pkg::BAND_RST;
      bit_idx_ff <= 3'h7;
    end else if (state_ff == synth_cal_pkg::CAL_RUN && step_done) begin
      if (above) band_ff[bit_idx_ff] <= 1'b0;
      if (bit_idx_ff != 3'h0) begin
        band_ff[bit_idx_ff - 3'h1] <= 1'b1;
        bit_idx_ff <= bit_idx_ff - 3'h1;
      end
    end
  end

  // First calibration after chip or loop reset holds the distribution
  logic first_cal_ff;
  logic busy;
  assign busy = (state_ff != synth_cal_pkg::CAL_IDLE);

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) first_cal_ff <= 1'b1;
    else if (loop_rst_rise) first_cal_ff <= 1'b1;
    else if (busy && nxt_state == synth_cal_pkg::CAL_IDLE) first_cal_ff <= 1'b0;
  end

  // Post-dividers
  post_div_if pd_bus ();
  assign pd_bus.ratio[0]   = act_ratio_ff[synth_cal_pkg::RATIO_PRI_LSB +: 4];
  assign pd_bus.ratio[1]   = act_ratio_ff[synth_cal_pkg::RATIO_SEC_LSB +: 4];
  assign pd_bus.rst_req[0] = act_pd_rst_ff[0] | busy;
  assign pd_bus.rst_req[1] = act_pd_rst_ff[1] | busy;

  post_divider_ctrl u_post_div (
    .clk_sys (clk_sys),
    .rstn    (rstn),
    .pd      (pd_bus.div)
  );

  assign primary_post_divider       = pd_bus.divide[0];
  assign primary_post_divider_on    = pd_bus.powered[0];
  assign primary_post_divider_rst   = pd_bus.in_reset[0];
  assign secondary_post_divider     = pd_bus.divide[1];
  assign secondary_post_divider_on  = pd_bus.powered[1];
  assign secondary_post_divider_rst = pd_bus.in_reset[1];

  // Registered loop controls
  logic [7:0] pump_code_ff;
  logic [9:0] pump_ua_ff;
  logic       fext_ff;
  logic [7:0] fcomp_ff;
  logic [1:0] rpole_ff;
  logic [1:0] loop_ff;
  logic [7:0] band_out_ff;
  logic [3:0] ch_src_ff;
  logic       hold_ff;
  logic       busy_ff;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      pump_code_ff <= synth_cal_pkg::PUMP_RST;
      pump_ua_ff   <= 10'h000;
      fext_ff      <= 1'b0;
      fcomp_ff     <= synth_cal_pkg::REG_RST;
      rpole_ff     <= 2'h0;
    end else begin
      pump_code_ff <= act_pump_ff;
      pump_ua_ff   <= {2'h0, act_pump_ff} * synth_cal_pkg::PUMP_STEP_UA;
      fext_ff      <= act_fsel_ff;
      fcomp_ff     <= act_fsel_ff ? 8'h00 : act_filter_ff;
      rpole_ff     <= act_filter_ff[synth_cal_pkg::RES_MSB:synth_cal_pkg::RES_LSB];
    end
  end

  // Loop mode 2 cannot calibrate through its own feedback, so mode 0 stands in
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      loop_ff     <= synth_cal_pkg::LOOP_RST;
      band_out_ff <= synth_cal_pkg::BAND_RST;
      ch_src_ff   <= synth_cal_pkg::CH_SRC_RST;
      hold_ff     <= 1'b0;
      busy_ff     <= 1'b0;
    end else begin
      loop_ff     <= (busy && act_loop_ff == synth_cal_pkg::LOOP_MODE2) ? synth_cal_pkg::LOOP_MODE0
                                                                       : act_loop_ff;
      band_out_ff <= band_ff;
      ch_src_ff   <= act_ch_src_ff & synth_cal_pkg::SEC_ALLOWED;
      hold_ff     <= busy && first_cal_ff;
      busy_ff     <= busy;
    end
  end

  assign pump_current_code      = pump_code_ff;
  assign pump_current_ua        = pump_ua_ff;
  assign filter_external        = fext_ff;
  assign filter_components      = fcomp_ff;
  assign second_pole_resistor   = rpole_ff;
  assign loop_mode              = loop_ff;
  assign main_oscillator_band   = band_out_ff;
  assign channel_from_secondary = ch_src_ff;
  assign distribution_hold      = hold_ff;
  assign cal_busy               = busy_ff;

  // Read port: data in the cycle after the strobe, zero otherwise and when unmapped
  logic [7:0] rd_mux;

  always_comb begin
    rd_mux = 8'h00;
    case (reg_addr)
      synth_cal_pkg::ADDR_STATUS:    rd_mux[synth_cal_pkg::STATUS_BUSY_BIT] = busy_ff;
      synth_cal_pkg::ADDR_CAL_CTRL:  rd_mux = sh_cal_ff;
      synth_cal_pkg::ADDR_LOOP_MODE: rd_mux[synth_cal_pkg::LOOP_MODE_MSB:synth_cal_pkg::LOOP_MODE_LSB] = sh_loop_ff;
      synth_cal_pkg::ADDR_PUMP:      rd_mux = sh_pump_ff;
      synth_cal_pkg::ADDR_FILTER:    rd_mux = sh_filter_ff;
      synth_cal_pkg::ADDR_FSEL:      rd_mux[synth_cal_pkg::FSEL_BIT] = sh_fsel_ff;
      synth_cal_pkg::ADDR_PD_RESET:  rd_mux = sh_pd_rst_ff;
      synth_cal_pkg::ADDR_PD_RATIO:  rd_mux = sh_ratio_ff;
      synth_cal_pkg::ADDR_CH_SRC:    rd_mux[3:0] = sh_ch_src_ff;
      default:                       rd_mux = 8'h00;
    endcase
  end

  logic [7:0] rdata_ff;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) rdata_ff <= 8'h00;
    else rdata_ff <= reg_rd ? rd_mux : 8'h00;
  end

  assign reg_rdata = rdata_ff;

endmodule : synth_divider_calibration_ctrl

// File: synth_divider_calibration_ctrl_monitor.sv
// Port checker for the synthesizer control block
`timescale 1ns/1ps
module synth_divider_calibration_ctrl_monitor #(
  parameter int unsigned CAL_PFD_CYCLES = synth_cal_pkg::CAL_PFD_CYCLES
) (
  // Clock and reset
  input wire logic       clk_sys,
  input wire logic       rstn,
  // Register port
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  // Loop controls
  input wire logic [7:0] pump_current_code,
  input wire logic [9:0] pump_current_ua,
  input wire logic       filter_external,
  input wire logic [7:0] filter_components,
  input wire logic [1:0] second_pole_resistor,
  input wire logic [1:0] loop_mode,
  // Post-dividers and distribution
  input wire logic [3:0] primary_post_divider,
  input wire logic       primary_post_divider_on,
  input wire logic       primary_post_divider_rst,
  input wire logic [3:0] secondary_post_divider,
  input wire logic       secondary_post_divider_on,
  input wire logic       secondary_post_divider_rst,
  input wire logic [3:0] channel_from_secondary,
  input wire logic       distribution_hold,
  input wire logic       cal_busy
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  sequence busy_start;
    $rose(cal_busy);
  endsequence
  sequence busy_run;
    cal_busy [*8];
  endsequence

  pump_scale_a: assert property (
    $past(rstn) && $past(rstn, 2) |-> pump_current_ua == {pump_current_code, 2'b00})
    else $error("pump current is not four times the code");
  ext_filter_a: assert property (filter_external |-> filter_components == 8'h00)
    else $error("filter components active in external mode");
  pole_res_a: assert property (
    !filter_external |-> second_pole_resistor == filter_components[7:6])
    else $error("resistor bits differ from filter field");
  pri_decode_a: assert property (
    primary_post_divider_on ? (primary_post_divider >= 4'h2 && primary_post_divider <= 4'hb)
                            : primary_post_divider == 4'h0)
    else $error("primary divider decode wrong");
  sec_decode_a: assert property (
    secondary_post_divider_on ? (secondary_post_divider >= 4'h2 && secondary_post_divider <= 4'hb)
                              : secondary_post_divider == 4'h0)
    else $error("secondary divider decode wrong");
  sec_route_a: assert property (
    channel_from_secondary[0] == 1'b0 && channel_from_secondary[3] == 1'b0)
    else $error("secondary feeds a forbidden channel");
  cal_reset_a: assert property (
    cal_busy |-> primary_post_divider_rst && secondary_post_divider_rst)
    else $error("post-dividers not reset during calibration");
  hold_busy_a: assert property (distribution_hold |-> cal_busy)
    else $error("distribution held outside calibration");
  busy_min_a: assert property (busy_start |-> busy_run)
    else $error("calibration ended too soon");
  mode_swap_a: assert property (cal_busy |-> loop_mode != 2'h2)
    else $error("loop mode two shown during calibration");
  rd_pulse_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside its cycle");
endmodule : synth_divider_calibration_ctrl_monitor

bind synth_divider_calibration_ctrl synth_divider_calibration_ctrl_monitor #(
  .CAL_PFD_CYCLES(CAL_PFD_CYCLES)) synth_divider_calibration_ctrl_monitor_i (
  .clk_sys(clk_sys), .rstn(rstn), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .pump_current_code(pump_current_code), .pump_current_ua(pump_current_ua),
  .filter_external(filter_external), .filter_components(filter_components),
  .second_pole_resistor(second_pole_resistor), .loop_mode(loop_mode),
  .primary_post_divider(primary_post_divider), .primary_post_divider_on(primary_post_divider_on),
  .primary_post_divider_rst(primary_post_divider_rst), .secondary_post_divider(secondary_post_divider),
  .secondary_post_divider_on(secondary_post_divider_on),
  .secondary_post_divider_rst(secondary_post_divider_rst),
  .channel_from_secondary(channel_from_secondary), .distribution_hold(distribution_hold),
  .cal_busy(cal_busy));

// File: synth_divider_calibration_ctrl_test.sv
// Self-checking bench for the synthesizer control block
`timescale 1ns/1ps
module synth_divider_calibration_ctrl_test;
  logic        clk_sys = 1'b0;
  logic        rstn = 1'b0;
  logic [11:0] addr = 12'h000;
  logic [7:0]  wdata = 8'h00;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic        pfd = 1'b0;
  logic        lost = 1'b1;
  logic        above = 1'b0;
  logic        ppd = 1'b0;
  logic        flr = 1'b0;
  logic [15:0] fbt = 16'h0000;
  logic [7:0]  rdata, code, comp, band, q;
  logic [9:0]  ua;
  logic [3:0]  pdp, pds, chs;
  logic [1:0]  res, mode;
  logic        fext, pon, prst, son, srst, hold, busy;
  int          fails = 0;
  int          checks_done = 0;
  int          pc = 0;
  int          el;
  int          sh [int];
  int          ac [int];
  logic [7:0]  pdr [4] = '{8'h11, 8'h01, 8'h10, 8'h00};

  always #20 clk_sys = ~clk_sys;
  // Phase detector pin: six system cycles a period
  always @(posedge clk_sys) begin
    pc <= (pc == 5) ? 0 : pc + 1;
    pfd <= pc < 3;
  end

  synth_divider_calibration_ctrl #(.CAL_PFD_CYCLES(80)) synth_divider_calibration_ctrl_i (
    .clk_sys(clk_sys), .rstn(rstn), .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd),
    .reg_rdata(rdata), .pfd_clk_pin(pfd), .reference_loss_flag(lost), .osc_above_target(above),
    .pin_strap_preset_done(ppd), .fractional_loop_reset(flr), .feedback_div_total(fbt),
    .pump_current_code(code), .pump_current_ua(ua), .filter_external(fext), .filter_components(comp),
    .second_pole_resistor(res), .loop_mode(mode), .main_oscillator_band(band),
    .primary_post_divider(pdp), .primary_post_divider_on(pon), .primary_post_divider_rst(prst),
    .secondary_post_divider(pds), .secondary_post_divider_on(son), .secondary_post_divider_rst(srst),
    .channel_from_secondary(chs), .distribution_hold(hold), .cal_busy(busy));

  task automatic end_sim();
    $display("Comparisons %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : end_sim

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic bus(input logic w, input logic [11:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    addr <= a;
    wdata <= d;
    wr <= w;
    rd <= !w;
    @(posedge clk_sys);
    wr <= 1'b0;
    rd <= 1'b0;
    #1 q = rdata;
  endtask : bus

  // Update code 0x01 applies every shadow at once
  task automatic wreg(input logic [11:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
    if (a == 12'h00f && d == 8'h01) ac = sh;
    else if (sh.exists(a)) sh[a] = (a == 12'h122) ? (d & 8'h06) : d;
  endtask : wreg

  task automatic settle();
    repeat (3) @(posedge clk_sys);
    #1;
  endtask : settle

  task automatic wait_busy(input logic v, input int n);
    for (el = 0; el < n && busy !== v; el++) begin
      @(posedge clk_sys);
      #1;
    end
    if (busy !== v) begin
      fails++;
      $display("Timeout waiting for calibration level %0b", v);
      end_sim();
    end
  endtask : wait_busy

  function automatic int dv(input int n);
    return (n >= 2 && n <= 11) ? n : 0;
  endfunction : dv

  task automatic outs();
    chk(code, ac[12'h102]);
    chk(ua, ac[12'h102] * 4);
    chk(fext, ac[12'h104] & 1);
    chk(comp, (ac[12'h104] & 1) ? 0 : ac[12'h103]);
    chk(res, ac[12'h103] >> 6);
    chk(pdp, dv(ac[12'h121] & 15));
    chk(pds, dv(ac[12'h121] >> 4));
    chk({son, pon}, {dv(ac[12'h121] >> 4) != 0, dv(ac[12'h121] & 15) != 0});
    chk(chs, ac[12'h122]);
    chk(mode, (ac[12'h101] >> 1) & 3);
  endtask : outs

  task automatic rdall();
    foreach (sh[a]) begin
      bus(1'b0, 12'(a), 8'h00);
      chk(q, sh[a]);
    end
    bus(1'b0, 12'h00f, 8'h00);
    chk(q, 0);
    bus(1'b0, 12'h0aa, 8'h00);
    chk(q, 0);
  endtask : rdall

  initial begin
    sh = '{12'h100: 0, 12'h101: 0, 12'h102: 8'h8d, 12'h103: 0, 12'h104: 0, 12'h120: 0, 12'h121: 0,
           12'h122: 0};
    ac = sh;
    void'($urandom(93291));
    repeat (4) @(posedge clk_sys);
    rstn <= 1'b1;
    settle();
    outs();
    chk(band, 8'h80);
    chk({busy, hold}, 0);
    rdall();
    $display("reset values done");
    for (int i = 0; i < 16; i++) begin
      wreg(12'h102, 8'($urandom));
      wreg(12'h103, 8'($urandom));
      wreg(12'h104, {7'h00, i[0]});
      wreg(12'h121, {i[3:0], 4'(15 - i)});
      wreg(12'h122, 8'($urandom));
      wreg(12'h101, 8'((i % 3) << 1));
      wreg(12'h00f, 8'h02);
      rdall();
      settle();
      outs();
      wreg(12'h00f, 8'h01);
      settle();
      outs();
    end
    $display("staged controls done");
    foreach (pdr[k]) begin
      wreg(12'h120, pdr[k]);
      wreg(12'h00f, 8'h01);
      settle();
      chk({srst, prst}, {sh[12'h120][4], sh[12'h120][0]});
    end
    $display("post-divider reset done");
    above <= 1'($urandom);
    wreg(12'h101, 8'h00);
    wreg(12'h100, 8'h08);
    wreg(12'h00f, 8'h01);
    wait_busy(1'b1, 4);
    chk(hold, 1);
    chk({prst, srst}, 3);
    bus(1'b0, 12'h020, 8'h00);
    chk(q[2], 1);
    repeat (700) @(posedge clk_sys);
    #1 chk({busy, band}, {1'b1, 8'h80});
    lost <= 1'b0;
    wait_busy(1'b0, 700);
    chk(el >= 470 && el <= 500, 1);
    chk(band, above ? 8'h00 : 8'hff);
    chk(hold, 0);
    bus(1'b0, 12'h020, 8'h00);
    chk(q[2], 0);
    wreg(12'h00f, 8'h01);
    settle();
    chk(busy, 0);
    bus(1'b0, 12'h100, 8'h00);
    chk(q, 8'h08);
    $display("first calibration done");
    wreg(12'h104, 8'h01);
    for (int k = 0; k < 2; k++) begin
      lost <= 1'b1;
      fbt <= 16'h01ff + 16'(k);
      wreg(12'h121, 8'h44);
      wreg(12'h101, 8'h02);
      wreg(12'h100, 8'h00);
      wreg(12'h00f, 8'h01);
      wreg(12'h100, 8'h08);
      wreg(12'h00f, 8'h01);
      wait_busy(1'b1, 4);
      chk(hold, 0);
      repeat (700) @(posedge clk_sys);
      #1 chk(busy, k == 0);
      lost <= 1'b0;
      wait_busy(1'b0, 700);
    end
    $display("loop mode one gating done");
    wreg(12'h101, 8'h04);
    wreg(12'h00f, 8'h01);
    flr <= 1'b1;
    settle();
    flr <= 1'b0;
    ppd <= 1'b1;
    wait_busy(1'b1, 8);
    chk({hold, mode}, {1'b1, 2'h0});
    ppd <= 1'b0;
    wait_busy(1'b0, 700);
    settle();
    chk(mode, 2);
    $display("preset calibration done");
    end_sim();
  end
endmodule : synth_divider_calibration_ctrl_test
